// >>> core/xad_pkg.sv
// Constants, field layout and carrier types of the extension-bus decoder.
// Assumes an APB master with 32-bit data and an LPC front end on clk.
// Summary of operation
// - Five enabled I/O zones, each own select
// - User I/O zones sized 2^n, n<=8
// - Fifth zone decodes debug port only
// - Unassigned zone is never claimed or forwarded
// - Seven registers define the I/O map
// - I/O lock bit freezes I/O mapping
// - User memory and BIOS zones enabled separately
// - Boot strap sets memory config one default
// - LPC BIOS enable claims legacy and high window
// - Extended BIOS range only when enabled
// - High window 256K to 32M, size fields
// - Hub enable claims hub reads in window
// - Hub access uses ID plus low 24 address bits
// - Strapped reset sets both BIOS enables
// - First BIOS read picks boot protocol
// - Later cycles keep enables; software may reset
// - Memory base is high, low, sixteen zeros
// - Memory lock bit freezes config two, base and size
// - Extension address is low 28 bits
// - Read data returned, write data passed
// - Debug enable maps I/O address 80h
// - Odd zone starts at base plus size
// - I/O lock makes seven registers read-only
package xad_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_IO_CFG = 8'hF0;
   localparam logic [7:0] IDX_MEM_CFG1 = 8'hF7;
   localparam logic [7:0] IDX_MEM_CFG2 = 8'hF8;
   localparam logic [7:0] IDX_MEM_SIZE = 8'hFB;
   localparam logic [7:0] IDX_STATUS = 8'hFD;
   localparam logic [7:0] IDX_UNLOCK = 8'hFE;
   localparam int NREG = 12;
   // Offsets inside the configuration array
   localparam int O_IOCFG = 0;
   localparam int O_IOSZ1 = 3;
   localparam int O_USER_MEM_ZONE_B = 7;
   localparam int O_MEM2 = 8;
   localparam int O_MBH = 9;
   localparam int O_MBL = 10;
   localparam int O_MSZ = 11;
   localparam int O_IOLAST = 6;
   // Field positions
   localparam int B_IO_LOCK = 7;
   localparam int B_DBG_EN = 4;
   localparam int B_BIOS_LPC = 0;
   localparam int B_BIOS_HUB = 1;
   localparam int B_BIOS_EXT = 2;
   localparam int B_UMEM_EN = 3;
   localparam int B_MEM_LOCK = 7;
   localparam int B_SEL2 = 3;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [15:0] DBG_ADDR = 16'h0080;
   localparam logic [15:0] LEG_BIOS = 16'h000F;
   localparam logic [15:0] EXT_BIOS = 16'h000E;
   localparam logic [4:0] WIN_MIN_EXP = 5'h12;
   localparam logic [4:0] WIN_MAX_EXP = 5'h19;
   localparam logic [3:0] IO_MAX_N = 4'h8;
   localparam logic [4:0] MEM_EXP0 = 5'h10;
   localparam logic [3:0] HUB_TOP = 4'hF;
   localparam int NSEL = 7;
   typedef enum logic [1:0] {CYC_IO, CYC_MEM, CYC_HUB, CYC_NONE} xad_kind_e;
   typedef struct packed {
      xad_kind_e kind;
      logic write;
      logic [31:0] addr;
      logic [3:0] id;
      logic [7:0] wdata;
   } xad_cyc_s;
   typedef struct packed {
      logic [27:0] addr;
      logic write;
      logic [7:0] wdata;
      logic [6:0] sel;
   } xad_ext_s;
endpackage

// >>> core/xad_decoder.sv
// Decoder that forwards LPC I/O, memory and hub cycles to the extension bus.
// Assumes cycle requests and extension answers arrive on clk; strap is a pin.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
module xad_decoder #(
   parameter int ADDR_W = 10
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_strap_input,
   input wire logic cyc_valid,
   input wire xad_pkg::xad_cyc_s cyc,
   input wire logic [6:0] zone_assigned,
   output logic cyc_claim,
   output logic ext_req,
   output xad_pkg::xad_ext_s ext,
   input wire logic ext_done,
   input wire logic [7:0] ext_rdata,
   output logic lpc_done,
   output logic [7:0] lpc_rdata
);
   typedef enum logic {ST_IDLE, ST_WAIT} xad_st_e;
   logic [7:0] cfg_q [xad_pkg::NREG];
   xad_st_e st_q;
   logic det_done_q;
   logic strap_s1_q, strap_s2_q;
   logic [1:0] boot_cnt_q;
   logic pend_bios_q, pend_wr_q;
   xad_pkg::xad_kind_e pend_kind_q;
   logic [31:0] prdata_q;
   logic cyc_claim_q, ext_req_q, lpc_done_q;
   xad_pkg::xad_ext_s ext_q;
   logic [7:0] lpc_rdata_q;

   // APB decode; registers sit at index F0h to FBh plus two extras
   logic [7:0] idx;
   logic acc, wr, in_cfg, mapped;
   logic [3:0] off;
   assign idx = paddr[9:2];
   assign acc = psel && penable;
   assign wr = acc && pwrite && pstrb[0];
   assign in_cfg = idx >= xad_pkg::IDX_IO_CFG
      && idx <= xad_pkg::IDX_MEM_SIZE;
   assign off = idx[3:0];
   assign mapped = in_cfg || idx == xad_pkg::IDX_STATUS
      || idx == xad_pkg::IDX_UNLOCK;
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata = prdata_q;

   logic io_lock, mem_lock;
   assign io_lock = cfg_q[xad_pkg::O_IOCFG][xad_pkg::B_IO_LOCK];
   assign mem_lock = cfg_q[xad_pkg::O_MEM2][xad_pkg::B_MEM_LOCK];

   // Strap pin crosses into clk through two flops
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end else begin
         strap_s1_q <= boot_strap_input;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Counts edges after release so the strap is read once it has settled
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         boot_cnt_q <= 2'h0;
      end else if (boot_cnt_q != 2'h3) begin
         boot_cnt_q <= boot_cnt_q + 2'h1;
      end
   end
   logic strap_ld;
   assign strap_ld = boot_cnt_q == 2'h2;

   // I/O zone decode for the two base/size pairs
   logic [15:0] io_a;
   logic [4:0] io_hit;
   assign io_a = cyc.addr[15:0];
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_io
         logic [3:0] n;
         logic [15:0] sz, msk, base, zb;
         localparam int P = 3 * (k / 2);
         always_comb begin
            n = cfg_q[xad_pkg::O_IOSZ1 + P][3:0];
            if (n > xad_pkg::IO_MAX_N) begin
               n = xad_pkg::IO_MAX_N;
            end
            sz = 16'h0001 << n;
            msk = ~(sz - 16'h0001);
            base = {cfg_q[P + 1], cfg_q[P + 2]};
            zb = (k % 2 == 1) ? base + sz : base;
         end
         assign io_hit[k] = cfg_q[xad_pkg::O_IOCFG][k]
            && (io_a & msk) == (zb & msk);
      end
   endgenerate
   // Debug port zone answers one address only
   assign io_hit[4] = cfg_q[xad_pkg::O_IOCFG][xad_pkg::B_DBG_EN]
      && io_a == xad_pkg::DBG_ADDR;

   // BIOS window: 256K doubled by size, once more by second select
   logic [4:0] wexp;
   logic [31:0] wlow, haddr, ulow, ubase;
   logic [4:0] uexp;
   logic [3:0] un;
   logic [7:0] m1, m2;
   assign m1 = cfg_q[xad_pkg::O_USER_MEM_ZONE_B];
   assign m2 = cfg_q[xad_pkg::O_MEM2];
   always_comb begin
      wexp = xad_pkg::WIN_MIN_EXP + {2'h0, m2[2:0]}
         + {4'h0, m2[xad_pkg::B_SEL2]};
      if (wexp > xad_pkg::WIN_MAX_EXP) begin
         wexp = xad_pkg::WIN_MAX_EXP;
      end
      wlow = (32'h0000_0001 << wexp) - 32'h0000_0001;
      un = cfg_q[xad_pkg::O_MSZ][3:0];
      if (un > xad_pkg::IO_MAX_N) begin
         un = xad_pkg::IO_MAX_N;
      end
      uexp = xad_pkg::MEM_EXP0 + {1'b0, un};
      ulow = (32'h0000_0001 << uexp) - 32'h0000_0001;
   end
   // Hub address: fixed Fh top nibble, then the ID field in place of address bits 27:24
   assign haddr = {xad_pkg::HUB_TOP, cyc.id, cyc.addr[23:0]};
   assign ubase = {cfg_q[xad_pkg::O_MBH], cfg_q[xad_pkg::O_MBL],
      16'h0000};
   // Forwarded address; hub cycles carry no upper bits of their own
   logic [31:0] fwd_a;
   assign fwd_a = (cyc.kind == xad_pkg::CYC_HUB) ? haddr : cyc.addr;

   logic lpc_win, hub_win, leg_hit, ext_hit, lpc_bios, hub_bios, umem;
   assign lpc_win = (cyc.addr | wlow) == 32'hFFFF_FFFF;
   assign hub_win = (haddr | wlow) == 32'hFFFF_FFFF;
   assign leg_hit = cyc.addr[31:16] == xad_pkg::LEG_BIOS;
   assign ext_hit = cyc.addr[31:16] == xad_pkg::EXT_BIOS
      && m1[xad_pkg::B_BIOS_EXT];
   assign lpc_bios = m1[xad_pkg::B_BIOS_LPC]
      && (leg_hit || ext_hit || lpc_win);
   assign hub_bios = m1[xad_pkg::B_BIOS_HUB] && !cyc.write
      && hub_win;
   assign umem = m1[xad_pkg::B_UMEM_EN]
      && (cyc.addr | ulow) == (ubase | ulow);

   // Zone selects of the current cycle, gated by kind
   logic [6:0] sel, sel_ok;
   logic is_bios, take;
   always_comb begin
      sel = 7'h00;
      is_bios = 1'b0;
      case (cyc.kind)
         xad_pkg::CYC_IO: sel[4:0] = io_hit;
         xad_pkg::CYC_MEM: begin
            sel[5] = umem;
            sel[6] = lpc_bios;
            is_bios = lpc_bios;
         end
         xad_pkg::CYC_HUB: begin
            sel[6] = hub_bios;
            is_bios = hub_bios;
         end
         default: sel = 7'h00;
      endcase
   end
   assign sel_ok = sel & zone_assigned;
   assign take = cyc_valid && st_q == ST_IDLE
      && sel_ok != 7'h00;

   // Forwarding sequence: claim, hold until extension answers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: if (take) st_q <= ST_WAIT;
            ST_WAIT: if (ext_done) st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Extension request fields; address cut to 28 bits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_q <= '0;
         ext_req_q <= 1'b0;
         cyc_claim_q <= 1'b0;
         pend_bios_q <= 1'b0;
         pend_wr_q <= 1'b0;
         pend_kind_q <= xad_pkg::CYC_NONE;
      end else begin
         ext_req_q <= take;
         cyc_claim_q <= take;
         if (take) begin
            ext_q.addr <= fwd_a[27:0];
            ext_q.write <= cyc.write;
            ext_q.wdata <= cyc.wdata;
            ext_q.sel <= sel_ok;
            pend_bios_q <= is_bios;
            pend_wr_q <= cyc.write;
            pend_kind_q <= cyc.kind;
         end
      end
   end

   // Read data goes back to LPC when the extension finishes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lpc_done_q <= 1'b0;
         lpc_rdata_q <= 8'h00;
      end else begin
         lpc_done_q <= st_q == ST_WAIT && ext_done;
         if (st_q == ST_WAIT && ext_done && !pend_wr_q) begin
            lpc_rdata_q <= ext_rdata;
         end
      end
   end
   assign cyc_claim = cyc_claim_q;
   assign ext_req = ext_req_q;
   assign ext = ext_q;
   assign lpc_done = lpc_done_q;
   assign lpc_rdata = lpc_rdata_q;

   // First completed BIOS read decides the protocol
   logic det_ev;
   assign det_ev = st_q == ST_WAIT && ext_done && pend_bios_q
      && !pend_wr_q && !det_done_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         det_done_q <= 1'b0;
      end else if (det_ev) begin
         det_done_q <= 1'b1;
      end
   end

   // Configuration array; strap load, detection and APB share one writer.
   // A software write of 1 lands after the hardware clear, so it wins.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < xad_pkg::NREG; i++) begin
            cfg_q[i] <= xad_pkg::RST_REG;
         end
      end else begin
         if (strap_ld && strap_s2_q) begin
            cfg_q[xad_pkg::O_USER_MEM_ZONE_B][xad_pkg::B_BIOS_LPC] <= 1'b1;
            cfg_q[xad_pkg::O_USER_MEM_ZONE_B][xad_pkg::B_BIOS_HUB] <= 1'b1;
         end
         if (det_ev) begin
            if (pend_kind_q == xad_pkg::CYC_MEM) begin
               cfg_q[xad_pkg::O_USER_MEM_ZONE_B][xad_pkg::B_BIOS_HUB] <= 1'b0;
            end else begin
               cfg_q[xad_pkg::O_USER_MEM_ZONE_B][xad_pkg::B_BIOS_LPC] <= 1'b0;
            end
         end
         if (wr && in_cfg) begin
            if (int'(off) <= xad_pkg::O_IOLAST) begin
               if (!io_lock) begin
                  cfg_q[off] <= pwdata[7:0];
               end
            end else if (int'(off) == xad_pkg::O_USER_MEM_ZONE_B) begin
               cfg_q[off] <= pwdata[7:0];
            end else if (!mem_lock) begin
               cfg_q[off] <= pwdata[7:0];
            end
         end
         // Unlock register clears the locks explicitly
         if (wr && idx == xad_pkg::IDX_UNLOCK) begin
            if (pwdata[0]) begin
               cfg_q[xad_pkg::O_IOCFG][xad_pkg::B_IO_LOCK] <= 1'b0;
            end
            if (pwdata[1]) begin
               cfg_q[xad_pkg::O_MEM2][xad_pkg::B_MEM_LOCK] <= 1'b0;
            end
         end
      end
   end

   // Read data staged in the setup phase so the access needs no wait
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         if (in_cfg) begin
            prdata_q <= {24'h000000, cfg_q[off]};
         end else if (idx == xad_pkg::IDX_STATUS) begin
            prdata_q <= {28'h0000000, strap_s2_q,
               st_q == ST_WAIT, det_done_q, 1'b0};
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // Checks on the forwarding path and the mapping registers
   AST_NO_HIT: assert property (@(posedge clk)
      disable iff (sys_rst)
      cyc_valid && st_q == ST_IDLE && sel == 7'h00 |=> !ext_req && !cyc_claim)
      else $error("cycle without hit was forwarded");
   AST_HIT_FWD: assert property (@(posedge clk)
      disable iff (sys_rst)
      take |=> ext_req && ext.sel == $past(sel_ok) ##1 !ext_req)
      else $error("hit did not give one request pulse");
   AST_UNASSIGNED: assert property (@(posedge clk)
      disable iff (sys_rst)
      cyc_valid && (sel & ~zone_assigned) != 7'h00
      && (sel & zone_assigned) == 7'h00 |=> !ext_req)
      else $error("unassigned zone was claimed");
   AST_ADDR28: assert property (@(posedge clk)
      disable iff (sys_rst)
      take |=> ext.addr == $past(fwd_a[27:0]))
      else $error("extension address is not low 28 bits");
   AST_IO_LOCK: assert property (@(posedge clk)
      disable iff (sys_rst)
      io_lock && wr && in_cfg && int'(off) <= xad_pkg::O_IOLAST
      |=> $stable(cfg_q[off]))
      else $error("locked I/O map changed");
   AST_RDATA: assert property (@(posedge clk)
      disable iff (sys_rst)
      st_q == ST_WAIT && ext_done && !pend_wr_q
      |=> lpc_done && lpc_rdata == $past(ext_rdata))
      else $error("read data not returned");
   AST_DET_HOLD: assert property (@(posedge clk)
      disable iff (sys_rst)
      det_done_q && !(wr && in_cfg)
      |=> $stable(cfg_q[xad_pkg::O_USER_MEM_ZONE_B][1:0]))
      else $error("BIOS enables changed after detection");
   AST_DBG: assert property (@(posedge clk)
      disable iff (sys_rst)
      cyc_valid && st_q == ST_IDLE && cyc.kind == xad_pkg::CYC_IO
      && io_a == xad_pkg::DBG_ADDR && zone_assigned[4]
      && cfg_q[xad_pkg::O_IOCFG][xad_pkg::B_DBG_EN] |=> ext_req && ext.sel[4])
      else $error("debug port not forwarded");
   AST_STRAP: assert property (@(posedge clk)
      disable iff (sys_rst)
      strap_ld && strap_s2_q |=> m1[1:0] == 2'h3)
      else $error("strap did not set both BIOS enables");
   // Memory lock must hold every register from the second config onward
   AST_MEM_LOCK: assert property (@(posedge clk)
      disable iff (sys_rst)
      mem_lock && wr && in_cfg && int'(off) >= xad_pkg::O_MEM2
      |=> $stable(cfg_q[off]))
      else $error("locked memory map changed");
   // Detection clears the other protocol unless software rewrites it
   AST_DET_MEM: assert property (@(posedge clk)
      disable iff (sys_rst)
      det_ev && pend_kind_q == xad_pkg::CYC_MEM
      && !(wr && in_cfg) && !strap_ld |=> !m1[xad_pkg::B_BIOS_HUB])
      else $error("memory boot did not clear hub enable");
   AST_DET_HUB: assert property (@(posedge clk)
      disable iff (sys_rst)
      det_ev && pend_kind_q == xad_pkg::CYC_HUB
      && !(wr && in_cfg) && !strap_ld |=> !m1[xad_pkg::B_BIOS_LPC])
      else $error("hub boot did not clear memory enable");
   AST_HUB_WR: assert property (@(posedge clk)
      disable iff (sys_rst)
      cyc_valid && cyc.kind == xad_pkg::CYC_HUB && cyc.write |=> !ext_req)
      else $error("hub write was forwarded");
   AST_WDATA: assert property (@(posedge clk)
      disable iff (sys_rst)
      take |=> ext.wdata == $past(cyc.wdata) && ext.write == $past(cyc.write))
      else $error("write data not passed on");
   // Extended range stays dark while its enable is clear
   AST_EXT_OFF: assert property (@(posedge clk)
      disable iff (sys_rst)
      cyc_valid && cyc.kind == xad_pkg::CYC_MEM && !m1[xad_pkg::B_BIOS_EXT]
      && cyc.addr[31:16] == xad_pkg::EXT_BIOS && !umem |=> !ext_req)
      else $error("extended range claimed while disabled");
endmodule

// >>> test/xad_ext_model.sv
// Extension bus peripheral model answering forwarded cycles.
// Assumes ext_req pulses once and ext fields hold until the answer.
`timescale 1ns/10ps
module xad_ext_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] lag,
   input wire logic ext_req,
   input wire xad_pkg::xad_ext_s ext,
   output logic ext_done,
   output logic [7:0] ext_rdata
);
   logic busy_q;
   logic [3:0] cnt_q;
   // Answers lag+1 cycles after the request is seen; data is scrambled outside done on purpose
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         ext_done <= 1'b0;
         ext_rdata <= 8'h00;
      end else begin
         ext_done <= 1'b0;
         ext_rdata <= ~ext_rdata;
         if (ext_req) begin
            busy_q <= 1'b1;
            cnt_q <= lag;
         end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            ext_done <= 1'b1;
            ext_rdata <= ext.addr[7:0] ^ 8'h5A; // Address-keyed data
         end
      end
   end
endmodule

// >>> test/test_xad_decoder.sv
// Testbench: APB set-up plus LPC cycles forwarded to a peripheral model.
// Assumes zero-wait APB and the cycle handshake of the decoder.
`timescale 1ns/10ps
module test_xad_decoder;
   localparam xad_pkg::xad_kind_e K_IO = xad_pkg::CYC_IO;
   localparam xad_pkg::xad_kind_e K_MEM = xad_pkg::CYC_MEM;
   localparam xad_pkg::xad_kind_e K_HUB = xad_pkg::CYC_HUB;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cyc_claim, ext_req, ext_done, lpc_done;
   logic boot_strap_input = 1'b1;
   logic cyc_valid = 1'b0;
   xad_pkg::xad_cyc_s cyc = '0;
   logic [6:0] zone_assigned = 7'h7F;
   xad_pkg::xad_ext_s ext;
   logic [7:0] ext_rdata, lpc_rdata;
   logic [3:0] lag = 4'h0;
   logic [31:0] rv;
   logic re;
   int n_mismatch = 0;
   int num_checks = 0;

   // Free-running bus clock
   always #50 clk = ~clk;

   xad_decoder dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_strap_input(boot_strap_input), .cyc_valid(cyc_valid),
      .cyc(cyc), .zone_assigned(zone_assigned), .cyc_claim(cyc_claim),
      .ext_req(ext_req), .ext(ext), .ext_done(ext_done),
      .ext_rdata(ext_rdata), .lpc_done(lpc_done), .lpc_rdata(lpc_rdata));

   xad_ext_model peer (.clk(clk), .sys_rst(sys_rst), .lag(lag),
      .ext_req(ext_req), .ext(ext), .ext_done(ext_done),
      .ext_rdata(ext_rdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      // The wait ends once pready is seen high; the watchdog catches a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdv(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rv, {24'h0, exp});
      chk(re, 1'b0);
   endtask

   // One LPC cycle; es is the expected select, zero when not claimed
   task automatic lpc(input xad_pkg::xad_kind_e k, input logic w,
      input logic [31:0] a, input logic [3:0] id, input logic [6:0] es);
      logic [27:0] ea;
      int i;
      ea = (k == K_HUB) ? {id, a[23:0]} : a[27:0];
      @(posedge clk);
      cyc_valid <= 1'b1;
      cyc <= '{kind: k, write: w, addr: a, id: id, wdata: 8'hC3};
      @(posedge clk);
      cyc_valid <= 1'b0;
      #1;
      chk(cyc_claim, es != 7'h00);
      chk(ext_req, es != 7'h00);
      if (es != 7'h00) begin
         chk(ext.sel, es);
         chk(ext.addr, ea);
         chk(ext.write, w);
         if (w) chk(ext.wdata, 8'hC3);
         i = 0;
         while (lpc_done !== 1'b1 && i < 20) begin
            @(posedge clk);
            #1;
            i++;
         end
         chk(lpc_done, 1'b1);
         if (!w) chk(lpc_rdata, ea[7:0] ^ 8'h5A);
      end else begin
         repeat (3) @(posedge clk);
         #1;
         chk(lpc_done, 1'b0);
      end
   endtask

   task automatic results();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard at 20000 cycles, far beyond the few hundred cycles of the sequence
   initial begin
      #2000000;
      n_mismatch++;
      results();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      rdv(8'hF0, 8'h00);
      rdv(8'hF7, 8'h03);
      rdv(8'hF8, 8'h00);
      apb(1'b0, 8'h00, 8'h00);
      chk(re, 1'b1);
      chk(rv, 32'h0);
      lpc(K_HUB, 1'b0, 32'h00FC0010, 4'hF, 7'h40);
      rdv(8'hF7, 8'h02);
      lpc(K_MEM, 1'b0, 32'hFFFC0010, 4'h0, 7'h00);
      apb(1'b1, 8'hF7, 8'h03);
      lpc(K_MEM, 1'b0, 32'hFFFC0020, 4'h0, 7'h40);
      lpc(K_HUB, 1'b0, 32'h00FC0030, 4'hF, 7'h40);
      rdv(8'hF7, 8'h03);
      lpc(K_HUB, 1'b0, 32'h00FC0030, 4'hE, 7'h00);
      lpc(K_HUB, 1'b1, 32'h00FC0030, 4'hF, 7'h00);
      lpc(K_MEM, 1'b1, 32'h000F1234, 4'h0, 7'h40);
      lpc(K_MEM, 1'b0, 32'h000E1234, 4'h0, 7'h00);
      apb(1'b1, 8'hF7, 8'h07);
      lpc(K_MEM, 1'b0, 32'h000E1234, 4'h0, 7'h40);
      lpc(K_MEM, 1'b0, 32'hFFF80000, 4'h0, 7'h00);
      apb(1'b1, 8'hF8, 8'h01);
      lpc(K_MEM, 1'b0, 32'hFFF80000, 4'h0, 7'h40);
      apb(1'b1, 8'hF8, 8'h0F);
      lpc(K_MEM, 1'b0, 32'hFE000000, 4'h0, 7'h40);
      lpc(K_MEM, 1'b0, 32'hFDFFFFFF, 4'h0, 7'h00);
      lag <= 4'h3;
      apb(1'b1, 8'hF9, 8'h12);
      apb(1'b1, 8'hFA, 8'h34);
      apb(1'b1, 8'hFB, 8'h00);
      lpc(K_MEM, 1'b0, 32'h1234ABCD, 4'h0, 7'h00);
      apb(1'b1, 8'hF7, 8'h0F);
      lpc(K_MEM, 1'b1, 32'h1234ABCD, 4'h0, 7'h20);
      lpc(K_MEM, 1'b0, 32'h12340001, 4'h0, 7'h20);
      lpc(K_MEM, 1'b0, 32'h12350000, 4'h0, 7'h00);
      apb(1'b1, 8'hF8, 8'h8F);
      apb(1'b1, 8'hF9, 8'h55);
      rdv(8'hF9, 8'h12);
      apb(1'b1, 8'hFE, 8'h02);
      apb(1'b1, 8'hF9, 8'h55);
      rdv(8'hF9, 8'h55);
      apb(1'b1, 8'hF1, 8'h03);
      apb(1'b1, 8'hF2, 8'h00);
      apb(1'b1, 8'hF3, 8'h04);
      apb(1'b1, 8'hF4, 8'h04);
      apb(1'b1, 8'hF5, 8'h00);
      apb(1'b1, 8'hF6, 8'h01);
      apb(1'b1, 8'hF0, 8'h1F);
      lag <= 4'h0;
      lpc(K_IO, 1'b0, 32'h00000305, 4'h0, 7'h01);
      lpc(K_IO, 1'b0, 32'h0000031F, 4'h0, 7'h02);
      lpc(K_IO, 1'b0, 32'h00000320, 4'h0, 7'h00);
      lpc(K_IO, 1'b0, 32'h00000401, 4'h0, 7'h04);
      lpc(K_IO, 1'b1, 32'h00000402, 4'h0, 7'h08);
      lpc(K_IO, 1'b0, 32'h00000080, 4'h0, 7'h10);
      lpc(K_IO, 1'b0, 32'h00000081, 4'h0, 7'h00);
      lpc(xad_pkg::CYC_NONE, 1'b0, 32'h00000080, 4'h0, 7'h00);
      zone_assigned <= 7'h7E;
      lpc(K_IO, 1'b0, 32'h00000305, 4'h0, 7'h00);
      zone_assigned <= 7'h7F;
      apb(1'b1, 8'hF0, 8'h9F);
      apb(1'b1, 8'hF0, 8'h00);
      rdv(8'hF0, 8'h9F);
      apb(1'b1, 8'hF1, 8'h77);
      rdv(8'hF1, 8'h03);
      lpc(K_IO, 1'b0, 32'h00000305, 4'h0, 7'h01);
      apb(1'b1, 8'hFE, 8'h01);
      apb(1'b1, 8'hF0, 8'h00);
      rdv(8'hF0, 8'h00);
      // Mid-run reset with the strap low: BIOS enables stay clear
      boot_strap_input <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      rdv(8'hF7, 8'h00);
      rdv(8'hF1, 8'h00);
      // Strapped reset again, this time a memory read boots first
      boot_strap_input <= 1'b1;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      lpc(K_MEM, 1'b0, 32'hFFFC0040, 4'h0, 7'h40);
      rdv(8'hF7, 8'h01);
      rdv(8'hFD, 8'h0A);
      results();
   end
endmodule
